// ===== design/ser_pkg.sv
// ser_pkg: constants for the status and event reporting block.
// assumes a 20 MHz system clock and a command decoder that hands in one
// command at a time on a valid strobe.
package ser_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int REG_W = 16;
    localparam int VOLT_W = 16;

    // ****************************************
    // commands presented by the decoder
    // ****************************************
    typedef enum logic [4:0] {
        SER_CMD_NONE,
        SER_CMD_RD_OPER_COND,
        SER_CMD_RD_OPER_EVENT,
        SER_CMD_WR_OPER_MASK,
        SER_CMD_RD_OPER_MASK,
        SER_CMD_RD_QUES_COND,
        SER_CMD_RD_QUES_EVENT,
        SER_CMD_WR_QUES_MASK,
        SER_CMD_RD_QUES_MASK,
        SER_CMD_PRESET,
        SER_CMD_WR_STAGED,
        SER_CMD_RD_STAGED,
        SER_CMD_TRIGGER,
        SER_CMD_WR_NEG_CEIL,
        SER_CMD_RD_NEG_CEIL,
        SER_CMD_WR_POS_CEIL,
        SER_CMD_RD_POS_CEIL,
        SER_CMD_BEEP
    } ser_cmd_t;

    // ****************************************
    // operation group bit positions
    // ****************************************
    localparam int OP_LIST_RUNNING = 14;
    localparam int OP_LIST_DONE = 12;
    localparam int OP_SAMPLE_DONE = 11;
    localparam int OP_CURRENT_REGULATING = 10;
    localparam int OP_TRANSIENT_DONE = 9;
    localparam int OP_VOLTAGE_REGULATING = 8;
    localparam int OP_TRANSIENT_ARMED = 6;
    localparam int OP_TRIGGER_WAIT = 5;
    localparam int OP_SETTLING_FLAG = 1;
    localparam logic [15:0] OP_USED_BITS = 16'h5F62;

    // ****************************************
    // questionable group bit positions
    // ****************************************
    localparam int QU_ABSORBING_ENERGY = 14;
    localparam int QU_CURRENT_ERROR = 13;
    localparam int QU_VOLTAGE_ERROR = 12;
    localparam int QU_SLAVE_ERROR = 6;
    localparam int QU_THERMAL_ERROR = 3;
    localparam int QU_CURRENT_MODE_ERROR = 1;
    localparam int QU_VOLTAGE_MODE_ERROR = 0;
    localparam logic [15:0] QU_USED_BITS = 16'h704B;
    localparam logic [15:0] QU_LATCH_BITS = 16'h3000;

    // ****************************************
    // preset and reset values
    // ****************************************
    localparam logic [15:0] OPER_MASK_PRESET = 16'h2001;
    localparam logic [15:0] QUES_MASK_PRESET = 16'h00FF;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // ****************************************
    // status byte summary bits and error code
    // ****************************************
    localparam int STB_OPER_BIT = 7;
    localparam int STB_QUES_BIT = 3;
    localparam logic [7:0] STB_ZERO = 8'h00;
    localparam logic [15:0] ERR_DATA_RANGE = 16'hFF22; // -222

    // ****************************************
    // beeper timing
    // ****************************************
    localparam int SYS_CLK_HZ = 20000000;
    localparam int BEEP_TIME_MS = 100;
    localparam int BEEP_CYCLES = SYS_CLK_HZ / 1000 * BEEP_TIME_MS;
endpackage : ser_pkg

// ===== design/ser_pulse_timer.sv
// ser_pulse_timer: stretches a one-cycle start strobe into a fixed pulse.
// assumes a synchronous active-low reset in the same clock domain.
`timescale 1ns/10ps
module ser_pulse_timer #(
    parameter int LENGTH = 2000000
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    output logic o_pulse
);
    import ser_pkg::*;

    localparam int CW = $clog2(LENGTH + 1);
    logic [CW-1:0] count_ff;

    // a fresh start while running restarts the full length
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            count_ff <= '0;
        end else if (i_start) begin
            count_ff <= CW'(LENGTH);
        end else if (count_ff != '0) begin
            count_ff <= count_ff - CW'(1);
        end
    end

    assign o_pulse = (count_ff != '0);
endmodule : ser_pulse_timer

// ===== design/ser_status_regs.sv
// ser_status_regs: operation and questionable status groups, summary bits,
// staged trigger voltage with clamping, protection limit ceilings and beeper.
// assumes the command decoder supplies one command per i_cmd_valid pulse and
// that the live condition inputs are synchronous to i_sys_clk.
`timescale 1ns/10ps
// What this block does
// - operation condition register shows live state, unlatched, 1 means active.
// - operation bits sit at 14, 12, 11, 10, 9, 8, 6, 5, 1; rest read zero.
// - status byte bit 7 is OR of enabled operation event bits.
// - operation event register is read-only and holds events until cleared.
// - reading operation event register returns it, then clears it.
// - operation mask is written by command and read back unchanged.
// - preset loads operation mask 8193 and questionable mask 255.
// - questionable event register read-only, latched, cleared on read.
// - only questionable bits 13 and 12 latch into the event register.
// - questionable bits 0 and 1 never latch, they follow live state.
// - questionable bits sit at 14, 13, 12, 6, 3, 1, 0; rest read zero.
// - questionable condition register shows live conditions, unlatched.
// - bits 1 and 0 may both be set while output settles.
// - status byte bit 3 is OR of enabled questionable event bits.
// - questionable mask is written by command and read back.
// - staged voltage applies on trigger; above model maximum posts -222.
// - staged voltage above high limit stores the limit instead.
// - staged voltage query returns the value awaiting the next trigger.
// - negative limit ceiling is held, up to 1% above rated voltage.
// - positive limit ceiling is held, up to 1% above rated, readable.
// - beep command produces one short pulse on the tone output.
module ser_status_regs #(
    parameter int BEEP_LEN = ser_pkg::BEEP_CYCLES,
    parameter logic [15:0] MODEL_MAX = 16'h0FA0,
    parameter logic [15:0] CEIL_MAX = 16'h0FCA,
    parameter logic [15:0] CEIL_RESET = 16'h0FCA
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    input wire ser_pkg::ser_cmd_t i_cmd,
    input wire logic [ser_pkg::REG_W-1:0] i_cmd_data,
    input wire logic [ser_pkg::REG_W-1:0] i_high_voltage_limit,
    input wire logic i_list_running,
    input wire logic i_list_done,
    input wire logic i_sample_done,
    input wire logic i_current_regulating,
    input wire logic i_transient_done,
    input wire logic i_voltage_regulating,
    input wire logic i_transient_armed,
    input wire logic i_trigger_wait,
    input wire logic i_settling_flag,
    input wire logic i_absorbing_energy,
    input wire logic i_current_error,
    input wire logic i_voltage_error,
    input wire logic i_slave_error,
    input wire logic i_thermal_error,
    input wire logic i_current_mode_error,
    input wire logic i_voltage_mode_error,
    output logic o_rsp_valid,
    output logic [ser_pkg::REG_W-1:0] o_rsp_data,
    output logic [7:0] o_status_byte,
    output logic o_err_valid,
    output logic [ser_pkg::REG_W-1:0] o_err_code,
    output logic o_apply_valid,
    output logic [ser_pkg::VOLT_W-1:0] o_apply_voltage,
    output logic [ser_pkg::VOLT_W-1:0] o_neg_ceiling,
    output logic [ser_pkg::VOLT_W-1:0] o_pos_ceiling,
    output logic o_tone
);
    import ser_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic summary(input logic [15:0] ev, input logic [15:0] mask);
        summary = |(ev & mask);
    endfunction : summary

    function automatic logic is_cmd(input logic valid, input ser_cmd_t c, input ser_cmd_t want);
        is_cmd = valid && (c == want);
    endfunction : is_cmd

    // ****************************************
    // live condition words
    // ****************************************
    logic [15:0] oper_cond;
    logic [15:0] ques_cond;

    always_comb begin
        oper_cond = ZERO16;
        oper_cond[OP_LIST_RUNNING] = i_list_running;
        oper_cond[OP_LIST_DONE] = i_list_done;
        oper_cond[OP_SAMPLE_DONE] = i_sample_done;
        oper_cond[OP_CURRENT_REGULATING] = i_current_regulating;
        oper_cond[OP_TRANSIENT_DONE] = i_transient_done;
        oper_cond[OP_VOLTAGE_REGULATING] = i_voltage_regulating;
        oper_cond[OP_TRANSIENT_ARMED] = i_transient_armed;
        oper_cond[OP_TRIGGER_WAIT] = i_trigger_wait;
        oper_cond[OP_SETTLING_FLAG] = i_settling_flag;
    end

    always_comb begin
        ques_cond = ZERO16;
        ques_cond[QU_ABSORBING_ENERGY] = i_absorbing_energy;
        ques_cond[QU_CURRENT_ERROR] = i_current_error;
        ques_cond[QU_VOLTAGE_ERROR] = i_voltage_error;
        ques_cond[QU_SLAVE_ERROR] = i_slave_error;
        ques_cond[QU_THERMAL_ERROR] = i_thermal_error;
        // both mode bits may be high together while settling
        ques_cond[QU_CURRENT_MODE_ERROR] = i_current_mode_error;
        ques_cond[QU_VOLTAGE_MODE_ERROR] = i_voltage_mode_error;
    end

    // ****************************************
    // command decode
    // ****************************************
    logic rd_oper_event;
    logic rd_ques_event;
    logic do_preset;
    assign rd_oper_event = is_cmd(i_cmd_valid, i_cmd, SER_CMD_RD_OPER_EVENT);
    assign rd_ques_event = is_cmd(i_cmd_valid, i_cmd, SER_CMD_RD_QUES_EVENT);
    assign do_preset = is_cmd(i_cmd_valid, i_cmd, SER_CMD_PRESET);

    // ****************************************
    // edge detection and event latching
    // ****************************************
    logic [15:0] oper_prev_ff;
    logic [15:0] ques_prev_ff;
    logic [15:0] oper_event_ff;
    logic [15:0] ques_event_ff;
    logic [15:0] oper_rise;
    logic [15:0] ques_rise;

    assign oper_rise = oper_cond & ~oper_prev_ff;
    assign ques_rise = ques_cond & ~ques_prev_ff & QU_LATCH_BITS;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            oper_prev_ff <= ZERO16;
            ques_prev_ff <= ZERO16;
        end else begin
            oper_prev_ff <= oper_cond;
            ques_prev_ff <= ques_cond;
        end
    end

    // a rise in the cycle of the clearing read is kept: set beats clear
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            oper_event_ff <= ZERO16;
        end else if (rd_oper_event) begin
            oper_event_ff <= oper_rise;
        end else begin
            oper_event_ff <= oper_event_ff | oper_rise;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ques_event_ff <= ZERO16;
        end else if (rd_ques_event) begin
            ques_event_ff <= ques_rise;
        end else begin
            ques_event_ff <= ques_event_ff | ques_rise;
        end
    end

    // ****************************************
    // enable masks
    // ****************************************
    logic [15:0] oper_mask_ff;
    logic [15:0] ques_mask_ff;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            oper_mask_ff <= MASK_RESET;
        end else if (do_preset) begin
            oper_mask_ff <= OPER_MASK_PRESET;
        end else if (is_cmd(i_cmd_valid, i_cmd, SER_CMD_WR_OPER_MASK)) begin
            oper_mask_ff <= i_cmd_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ques_mask_ff <= MASK_RESET;
        end else if (do_preset) begin
            ques_mask_ff <= QUES_MASK_PRESET;
        end else if (is_cmd(i_cmd_valid, i_cmd, SER_CMD_WR_QUES_MASK)) begin
            ques_mask_ff <= i_cmd_data;
        end
    end

    // ****************************************
    // status byte
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_status_byte <= STB_ZERO;
        end else begin
            o_status_byte <= STB_ZERO;
            o_status_byte[STB_OPER_BIT] <= summary(oper_event_ff, oper_mask_ff);
            o_status_byte[STB_QUES_BIT] <= summary(ques_event_ff, ques_mask_ff);
        end
    end

    // ****************************************
    // staged trigger voltage and ceilings
    // ****************************************
    logic [15:0] staged_ff;
    logic [15:0] neg_ceil_ff;
    logic [15:0] pos_ceil_ff;
    logic wr_staged;
    logic staged_too_big;
    assign wr_staged = is_cmd(i_cmd_valid, i_cmd, SER_CMD_WR_STAGED);
    assign staged_too_big = i_cmd_data > MODEL_MAX;

    // an out-of-range value is refused and the old staged value kept
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            staged_ff <= ZERO16;
        end else if (wr_staged && !staged_too_big) begin
            if (i_cmd_data > i_high_voltage_limit) begin
                staged_ff <= i_high_voltage_limit;
            end else begin
                staged_ff <= i_cmd_data;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_err_valid <= 1'b0;
            o_err_code <= ZERO16;
        end else begin
            o_err_valid <= wr_staged && staged_too_big;
            o_err_code <= (wr_staged && staged_too_big) ? ERR_DATA_RANGE : o_err_code;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_apply_valid <= 1'b0;
            o_apply_voltage <= ZERO16;
        end else begin
            o_apply_valid <= is_cmd(i_cmd_valid, i_cmd, SER_CMD_TRIGGER);
            if (is_cmd(i_cmd_valid, i_cmd, SER_CMD_TRIGGER)) begin
                o_apply_voltage <= staged_ff;
            end
        end
    end

    // ceilings reject values past rated plus one percent; saving them to
    // non-volatile memory is the host's job
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            neg_ceil_ff <= CEIL_RESET;
        end else if (is_cmd(i_cmd_valid, i_cmd, SER_CMD_WR_NEG_CEIL)
                     && i_cmd_data <= CEIL_MAX) begin
            neg_ceil_ff <= i_cmd_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pos_ceil_ff <= CEIL_RESET;
        end else if (is_cmd(i_cmd_valid, i_cmd, SER_CMD_WR_POS_CEIL)
                     && i_cmd_data <= CEIL_MAX) begin
            pos_ceil_ff <= i_cmd_data;
        end
    end

    assign o_neg_ceiling = neg_ceil_ff;
    assign o_pos_ceiling = pos_ceil_ff;

    // ****************************************
    // query responses
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_rsp_valid <= 1'b0;
            o_rsp_data <= ZERO16;
        end else begin
            o_rsp_valid <= 1'b0;
            if (i_cmd_valid) begin
                unique case (i_cmd)
                    SER_CMD_RD_OPER_COND: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= oper_cond & OP_USED_BITS;
                    end
                    SER_CMD_RD_OPER_EVENT: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= oper_event_ff;
                    end
                    SER_CMD_RD_OPER_MASK: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= oper_mask_ff;
                    end
                    SER_CMD_RD_QUES_COND: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= ques_cond & QU_USED_BITS;
                    end
                    SER_CMD_RD_QUES_EVENT: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= ques_event_ff;
                    end
                    SER_CMD_RD_QUES_MASK: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= ques_mask_ff;
                    end
                    SER_CMD_RD_STAGED: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= staged_ff;
                    end
                    SER_CMD_RD_NEG_CEIL: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= neg_ceil_ff;
                    end
                    SER_CMD_RD_POS_CEIL: begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_data <= pos_ceil_ff;
                    end
                    default: begin
                        o_rsp_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // beeper
    // ****************************************
    ser_pulse_timer #(
        .LENGTH(BEEP_LEN)
    ) u_beep (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_start(is_cmd(i_cmd_valid, i_cmd, SER_CMD_BEEP)),
        .o_pulse(o_tone)
    );
endmodule : ser_status_regs

// ===== dv/ser_status_regs_properties.sv
// ser_status_regs_properties: port-level timing checks on ser_status_regs
// assumes it is bound to the block and shares its MODEL_MAX setting
`timescale 1ns/10ps
module ser_status_regs_properties
    import ser_pkg::*;
#(
    parameter logic [15:0] MODEL_MAX = 16'h0FA0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    input wire ser_pkg::ser_cmd_t i_cmd,
    input wire logic [ser_pkg::REG_W-1:0] i_cmd_data,
    input wire logic o_rsp_valid,
    input wire logic [ser_pkg::REG_W-1:0] o_rsp_data,
    input wire logic [7:0] o_status_byte,
    input wire logic o_err_valid,
    input wire logic [ser_pkg::REG_W-1:0] o_err_code,
    input wire logic o_apply_valid,
    input wire logic [ser_pkg::VOLT_W-1:0] o_neg_ceiling,
    input wire logic [ser_pkg::VOLT_W-1:0] o_pos_ceiling
);
    // ****************************************
    // command decode
    // ****************************************
    wire rd_cmd = i_cmd_valid && (i_cmd inside {SER_CMD_RD_OPER_COND, SER_CMD_RD_OPER_EVENT,
        SER_CMD_RD_OPER_MASK, SER_CMD_RD_QUES_COND, SER_CMD_RD_QUES_EVENT,
        SER_CMD_RD_QUES_MASK, SER_CMD_RD_STAGED, SER_CMD_RD_NEG_CEIL, SER_CMD_RD_POS_CEIL});
    wire trig = i_cmd_valid && (i_cmd == SER_CMD_TRIGGER);
    wire bad_wr = i_cmd_valid && (i_cmd == SER_CMD_WR_STAGED) && (i_cmd_data > MODEL_MAX);
    wire preset = i_cmd_valid && (i_cmd == SER_CMD_PRESET);
    wire rd_om = i_cmd_valid && (i_cmd == SER_CMD_RD_OPER_MASK);
    wire wr_neg = i_cmd_valid && (i_cmd == SER_CMD_WR_NEG_CEIL);
    wire wr_pos = i_cmd_valid && (i_cmd == SER_CMD_WR_POS_CEIL);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    AST_RSP_LAT: assert property (rd_cmd |=> o_rsp_valid)
        else $error("query answer missing one cycle later");
    AST_RSP_CAUSE: assert property (o_rsp_valid |-> $past(rd_cmd))
        else $error("query answer without a query");
    AST_APPLY_LAT: assert property (trig |=> o_apply_valid)
        else $error("trigger not applied one cycle later");
    AST_APPLY_CAUSE: assert property (o_apply_valid |-> $past(trig))
        else $error("staged value applied without trigger");
    AST_RANGE_ERR: assert property (
        bad_wr |=> o_err_valid && o_err_code == ERR_DATA_RANGE)
        else $error("out of range staged value not flagged");
    AST_ERR_CAUSE: assert property (o_err_valid |-> $past(bad_wr))
        else $error("range error without a bad staged value");
    AST_PRESET: assert property (preset ##1 rd_om |=> o_rsp_data == OPER_MASK_PRESET)
        else $error("preset operation mask value wrong");
    AST_STB_SPARE: assert property ((o_status_byte & 8'h77) == 8'h00)
        else $error("status byte spare bit set");
    AST_NEG_HOLD: assert property (!wr_neg |=> $stable(o_neg_ceiling))
        else $error("negative ceiling moved without a write");
    AST_POS_HOLD: assert property (!wr_pos |=> $stable(o_pos_ceiling))
        else $error("positive ceiling moved without a write");
    COV_QUERY: cover property (rd_cmd ##1 rd_cmd);
    COV_TRIG: cover property (trig);
    COV_BAD: cover property (bad_wr);
endmodule : ser_status_regs_properties

bind ser_status_regs ser_status_regs_properties #(.MODEL_MAX(MODEL_MAX))
    ser_status_regs_properties_inst (.*);

// ===== dv/ser_host_model.sv
// ser_host_model: stands in for the host side that issues decoded commands
// assumes commands are taken on the rising clock edge while valid is high
`timescale 1ns/10ps
module ser_host_model
    import ser_pkg::*;
(
    input wire logic i_sys_clk,
    output logic o_cmd_valid,
    output ser_pkg::ser_cmd_t o_cmd,
    output logic [ser_pkg::REG_W-1:0] o_cmd_data
);
    // ****************************************
    // command issue
    // ****************************************
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = SER_CMD_NONE;
        o_cmd_data = 16'h0000;
    end
    // never issues a memory save, so ceilings are not expected past a reset
    task automatic send(input ser_cmd_t cmd, input logic [ser_pkg::REG_W-1:0] data);
        o_cmd_valid = 1'b1;
        o_cmd = cmd;
        o_cmd_data = data;
        @(posedge i_sys_clk);
        #1;
    endtask : send
    // released data is scrambled so nothing can lean on a stale word
    task automatic idle();
        o_cmd_valid = 1'b0;
        o_cmd_data = ~o_cmd_data;
        @(posedge i_sys_clk);
        #1;
    endtask : idle
endmodule : ser_host_model

// ===== dv/status_event_reporting_test.sv
// status_event_reporting_test: self-checking bench for ser_status_regs
// assumes the host model drives commands and the bench drives live conditions
`timescale 1ns/10ps
module status_event_reporting_test;
    import ser_pkg::*;
    typedef struct {ser_cmd_t cmd; logic [15:0] data; logic chk; logic [15:0] exp;} ser_row_t;
    localparam logic [15:0] VMAX = 16'h0FA0;
    localparam logic [15:0] CEIL_INIT = 16'h0FCA;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_cmd_valid;
    ser_cmd_t i_cmd;
    logic [15:0] i_cmd_data;
    logic [15:0] i_high_voltage_limit = 16'h0800;
    logic i_list_running, i_list_done, i_sample_done, i_current_regulating;
    logic i_transient_done, i_voltage_regulating, i_transient_armed, i_trigger_wait;
    logic i_settling_flag, i_absorbing_energy, i_current_error, i_voltage_error;
    logic i_slave_error, i_thermal_error, i_current_mode_error, i_voltage_mode_error;
    logic o_rsp_valid, o_err_valid, o_apply_valid, o_tone;
    logic [15:0] o_rsp_data, o_err_code, o_apply_voltage, o_neg_ceiling, o_pos_ceiling;
    logic [7:0] o_status_byte;
    int n_errors = 0;
    int cmp_count = 0;
    ser_row_t rows[16] = '{
        '{SER_CMD_WR_OPER_MASK, 16'h0500, 1'b0, 16'h0000},
        '{SER_CMD_RD_OPER_MASK, 16'h0000, 1'b1, 16'h0500},
        '{SER_CMD_WR_QUES_MASK, 16'h3000, 1'b0, 16'h0000},
        '{SER_CMD_RD_QUES_MASK, 16'h0000, 1'b1, 16'h3000},
        '{SER_CMD_PRESET, 16'h0000, 1'b0, 16'h0000},
        '{SER_CMD_RD_OPER_MASK, 16'h0000, 1'b1, 16'h2001},
        '{SER_CMD_RD_QUES_MASK, 16'h0000, 1'b1, 16'h00FF},
        '{SER_CMD_WR_NEG_CEIL, 16'h0F00, 1'b0, 16'h0000},
        '{SER_CMD_WR_NEG_CEIL, 16'h0FCB, 1'b0, 16'h0000},
        '{SER_CMD_RD_NEG_CEIL, 16'h0000, 1'b1, 16'h0F00},
        '{SER_CMD_WR_STAGED, 16'h0100, 1'b0, 16'h0000},
        '{SER_CMD_RD_STAGED, 16'h0000, 1'b1, 16'h0100},
        '{SER_CMD_WR_STAGED, 16'h0FA1, 1'b0, 16'h0000},
        '{SER_CMD_RD_STAGED, 16'h0000, 1'b1, 16'h0100},
        '{SER_CMD_WR_STAGED, 16'h0900, 1'b0, 16'h0000},
        '{SER_CMD_RD_STAGED, 16'h0000, 1'b1, 16'h0800}
    };

    ser_status_regs #(.BEEP_LEN(8), .MODEL_MAX(VMAX), .CEIL_RESET(CEIL_INIT))
        ser_status_regs_inst (.*);
    ser_host_model ser_host_model_inst (
        .i_sys_clk(i_sys_clk),
        .o_cmd_valid(i_cmd_valid),
        .o_cmd(i_cmd),
        .o_cmd_data(i_cmd_data)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input ser_cmd_t c, input logic [15:0] d);
        ser_host_model_inst.send(c, d);
    endtask : send
    task automatic query(input ser_cmd_t c, input logic [15:0] exp);
        ser_host_model_inst.send(c, 16'h0000);
        chk(o_rsp_data, exp);
    endtask : query
    task automatic set_cond(input logic [8:0] op, input logic [6:0] qu);
        {i_list_running, i_list_done, i_sample_done, i_current_regulating, i_transient_done,
            i_voltage_regulating, i_transient_armed, i_trigger_wait, i_settling_flag} = op;
        {i_absorbing_energy, i_current_error, i_voltage_error, i_slave_error,
            i_thermal_error, i_current_mode_error, i_voltage_mode_error} = qu;
    endtask : set_cond
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    // about 50 cycles of work; a long margin still ends a hang quickly
    initial begin
        #200000;
        n_errors++;
        $display("FAIL t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
        complete_run();
    end
    initial begin
        set_cond(9'h000, 7'h00);
        repeat (3) @(posedge i_sys_clk);
        #1;
        i_rst_b = 1'b1;
        chk({8'h00, o_status_byte}, 16'h0000);
        chk(o_neg_ceiling, CEIL_INIT);
        chk(o_pos_ceiling, CEIL_INIT);
        $display("test reset done");
        // rows run back to back, so valid stays high between them
        foreach (rows[i]) begin
            send(rows[i].cmd, rows[i].data);
            chk({15'h0000, o_rsp_valid}, {15'h0000, rows[i].chk});
            if (rows[i].chk) chk(o_rsp_data, rows[i].exp);
        end
        ser_host_model_inst.idle();
        $display("test table done");
        set_cond(9'h1FF, 7'h7F);
        repeat (3) @(posedge i_sys_clk);
        #1;
        // preset masks leave every captured bit unreported
        chk({8'h00, o_status_byte}, 16'h0000);
        query(SER_CMD_RD_OPER_COND, 16'h5F62);
        query(SER_CMD_RD_QUES_COND, 16'h704B);
        send(SER_CMD_WR_OPER_MASK, 16'h0002);
        send(SER_CMD_WR_QUES_MASK, 16'h1000);
        ser_host_model_inst.idle();
        chk({8'h00, o_status_byte}, 16'h0088);
        query(SER_CMD_RD_OPER_EVENT, 16'h5F62);
        query(SER_CMD_RD_OPER_EVENT, 16'h0000);
        query(SER_CMD_RD_QUES_EVENT, 16'h3000);
        query(SER_CMD_RD_QUES_EVENT, 16'h0000);
        ser_host_model_inst.idle();
        chk({8'h00, o_status_byte}, 16'h0000);
        set_cond(9'h1FF, 7'h7C);
        query(SER_CMD_RD_QUES_COND, 16'h7048);
        query(SER_CMD_RD_QUES_EVENT, 16'h0000);
        ser_host_model_inst.idle();
        $display("test events done");
        send(SER_CMD_WR_STAGED, 16'hFFFF);
        chk({15'h0000, o_err_valid}, 16'h0001);
        chk(o_err_code, ERR_DATA_RANGE);
        send(SER_CMD_TRIGGER, 16'h0000);
        chk({15'h0000, o_apply_valid}, 16'h0001);
        chk(o_apply_voltage, 16'h0800);
        send(SER_CMD_WR_POS_CEIL, 16'h0E00);
        chk(o_pos_ceiling, 16'h0E00);
        chk(o_neg_ceiling, 16'h0F00);
        send(SER_CMD_WR_POS_CEIL, 16'h0FCB);
        query(SER_CMD_RD_POS_CEIL, 16'h0E00);
        ser_host_model_inst.idle();
        chk({15'h0000, o_apply_valid}, 16'h0000);
        // tone length is the BEEP_LEN of 8 given at the instance
        send(SER_CMD_BEEP, 16'h0000);
        chk({15'h0000, o_tone}, 16'h0001);
        ser_host_model_inst.idle();
        repeat (6) @(posedge i_sys_clk);
        #1;
        chk({15'h0000, o_tone}, 16'h0001);
        @(posedge i_sys_clk);
        #1;
        chk({15'h0000, o_tone}, 16'h0000);
        $display("test trigger and ceilings done");
        complete_run();
    end
endmodule : status_event_reporting_test
